// file: wtu_watchdog.sv
// Purpose: fail-safe watchdog with 16-bit counter, reload byte and APB registers
// Assumes: instruction strobes are one-cycle pulses synchronous to ref_clk
// Notes:   overflow holds the internal reset request for RST_CYCLES cycles
//
// Functional notes
// - every reset leaves the counter running so start-up is supervised.
// - compatible mode accepts disable only before end of initialisation.
// - enhanced mode disables and enables on the instructions at any time.
// - overflow requests internal chip reset and drives reset indication low.
// - sixteen-bit counter advances at system clock divided by 2, 4, 128 or 256.
// - an eight-bit reload value is the starting high byte of the counter.
// - each service loads the high byte from reload and clears the low byte.
// - settings span roughly 13 us to 419 ms at 40 MHz.
// - default interval after reset is 3.28 ms at 40 MHz.
//
// The register addresses and the APB register port were chosen for this implementation.
`include "wtu_defines.svh"

module wtu_watchdog #(
	parameter int unsigned RST_CYCLES = `WTU_RST_CYCLES_DEF
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire wtu_pkg::wtu_instr_s   instr,
	input  wire logic [`WTU_ADDR_W-1:0] paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       chip_reset_req,
	output logic                       reset_indication_output_n,
	output logic                       irq
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (RST_CYCLES < 4 || RST_CYCLES > 4096) begin : g_chk_rst
		$error("wtu_watchdog: RST_CYCLES must lie in 4..4096");
	end
	// structural default interval must match the quoted figure within one percent
	if ((`WTU_STRUCT_CYCLES * 100 > `WTU_DEF_CYCLES * 101)
		|| (`WTU_STRUCT_CYCLES * 101 < `WTU_DEF_CYCLES * 100)) begin : g_chk_int
		$error("wtu_watchdog: default interval does not match the counter");
	end

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	wtu_pkg::wtu_state_e    st_r;
	wtu_pkg::wtu_state_e    st_nxt;
	wtu_pkg::wtu_div_e      pre_r;
	wtu_pkg::wtu_reload_t   reload_r;
	logic                   enh_r;
	logic                   init_done_r;
	logic [`WTU_CNT_W-1:0]  cnt_r;
	logic [12:0]            rst_cnt_r;
	logic [`WTU_IRQ_W-1:0]  irq_stat_r;
	logic [`WTU_IRQ_W-1:0]  irq_mask_r;
	logic [`WTU_IRQ_W-1:0]  irq_ev;
	logic [`WTU_IRQ_W-1:0]  irq_clr;
	logic [31:0]            prdata_r;
	logic                   pslverr_r;
	logic [31:0]            rd_data;
	logic                   rd_hit;
	logic                   tick;
	logic                   live;
	logic                   srv_eff;
	logic                   dis_ok;
	logic                   dis_ign;
	logic                   ovf;
	logic                   rst_done;
	logic                   apb_setup;
	logic                   apb_wr;
	logic                   apb_rd;
	logic                   seen_r;

	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------
	assign live     = (st_r != wtu_pkg::WTU_ST_RESET);
	assign srv_eff  = instr.service && live;
	// compatible mode lets disable through only before end of init
	assign dis_ok   = instr.timer_disable_instruction && live
		&& (enh_r || !init_done_r);
	assign dis_ign  = instr.timer_disable_instruction && live && !enh_r && init_done_r;
	// a timely service in the wrap cycle still counts as service
	assign ovf      = (st_r == wtu_pkg::WTU_ST_RUN) && tick
		&& (cnt_r == `WTU_CNT_MAX) && !instr.service;
	assign rst_done = (st_r == wtu_pkg::WTU_ST_RESET) && (rst_cnt_r == '0);

	// ---------------------------------------------------------------
	// prescaler
	// ---------------------------------------------------------------
	wtu_prescaler #(
		.WIDTH (8)
	) u_pre (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.enable  (st_r == wtu_pkg::WTU_ST_RUN),
		.clear   (srv_eff || !live),
		.sel     (pre_r),
		.tick    (tick)
	);

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			wtu_pkg::WTU_ST_RUN: begin
				if (ovf) begin
					st_nxt = wtu_pkg::WTU_ST_RESET;
				end else if (dis_ok && !(enh_r && instr.timer_enable_instruction)) begin
					st_nxt = wtu_pkg::WTU_ST_STOP;
				end
			end
			wtu_pkg::WTU_ST_STOP: begin
				// compatible mode stays off once disabled
				if (enh_r && instr.timer_enable_instruction) begin
					st_nxt = wtu_pkg::WTU_ST_RUN;
				end
			end
			wtu_pkg::WTU_ST_RESET: begin
				if (rst_done) begin
					st_nxt = wtu_pkg::WTU_ST_RUN;
				end
			end
			default: st_nxt = wtu_pkg::WTU_ST_RESET;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= wtu_pkg::WTU_ST_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_r <= '0;
		end else if (ovf) begin
			rst_cnt_r <= 13'(RST_CYCLES - 1);
		end else if (!live && rst_cnt_r != '0) begin
			rst_cnt_r <= rst_cnt_r - 1'b1;
		end
	end

	// end of the internal reset re-opens the initialisation window
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_done_r <= 1'b0;
		end else if (rst_done) begin
			init_done_r <= 1'b0;
		end else if (instr.end_of_init_instruction && live) begin
			init_done_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {`WTU_REL_RST, `WTU_LOW_CLR};
		end else if (srv_eff || ovf || !live) begin
			cnt_r <= {reload_r, `WTU_LOW_CLR};
		end else if (st_r == wtu_pkg::WTU_ST_RUN && tick) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// reset outputs
	// ---------------------------------------------------------------
	// both come straight from the one-hot state bit, so no glitch reaches the pins
	assign chip_reset_req            = st_r[`WTU_ST_RST_BIT];
	assign reset_indication_output_n = !st_r[`WTU_ST_RST_BIT];

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && !pslverr_r;
	assign apb_rd    = psel && penable && !pwrite;
	// zero wait states: data is prepared in the setup cycle
	assign pready    = 1'b1;
	assign prdata    = prdata_r;
	assign pslverr   = pslverr_r;

	always_comb begin
		rd_data = '0;
		rd_hit  = 1'b1;
		case (paddr)
			`WTU_OFF_CTRL: begin
				rd_data[`WTU_CTRL_PRE_MSB:`WTU_CTRL_PRE_LSB] = pre_r;
				rd_data[`WTU_CTRL_ENH_BIT]                   = enh_r;
				rd_data[`WTU_CTRL_REL_MSB:`WTU_CTRL_REL_LSB] = reload_r;
			end
			`WTU_OFF_COUNT:    rd_data[`WTU_CNT_W-1:0] = cnt_r;
			`WTU_OFF_STATE: begin
				rd_data[`WTU_ST_RUN_BIT]  = st_r[`WTU_ST_RUN_BIT];
				rd_data[`WTU_ST_INIT_BIT] = init_done_r;
				rd_data[`WTU_ST_RST_BIT]  = st_r[`WTU_ST_RST_BIT];
				rd_data[`WTU_ST_STOP_BIT] = (st_r == wtu_pkg::WTU_ST_STOP);
			end
			`WTU_OFF_IRQ_STAT: rd_data[`WTU_IRQ_W-1:0] = irq_stat_r;
			`WTU_OFF_IRQ_MASK: rd_data[`WTU_IRQ_W-1:0] = irq_mask_r;
			default:           rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else if (apb_setup) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr_r <= !rd_hit || (pwrite && paddr != `WTU_OFF_CTRL
				&& paddr != `WTU_OFF_IRQ_MASK);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r    <= wtu_pkg::wtu_div_e'(`WTU_PRE_RST);
			enh_r    <= `WTU_ENH_RST;
			reload_r <= `WTU_REL_RST;
		end else if (apb_wr && paddr == `WTU_OFF_CTRL) begin
			if (pstrb[0]) begin
				pre_r <= wtu_pkg::wtu_div_e'(pwdata[`WTU_CTRL_PRE_MSB:`WTU_CTRL_PRE_LSB]);
				enh_r <= pwdata[`WTU_CTRL_ENH_BIT];
			end
			if (pstrb[1]) begin
				reload_r <= pwdata[`WTU_CTRL_REL_MSB:`WTU_CTRL_REL_LSB];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= `WTU_MASK_RST;
		end else if (apb_wr && paddr == `WTU_OFF_IRQ_MASK && pstrb[0]) begin
			irq_mask_r <= pwdata[`WTU_IRQ_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	always_comb begin
		irq_ev                  = '0;
		irq_ev[`WTU_IRQ_OVF]    = ovf;
		irq_ev[`WTU_IRQ_DISIGN] = dis_ign;
		irq_ev[`WTU_IRQ_SRV]    = srv_eff;
	end

	// only the bits the reader saw are cleared; a new event always survives
	assign irq_clr = (apb_rd && paddr == `WTU_OFF_IRQ_STAT) ? prdata_r[`WTU_IRQ_W-1:0] : '0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_hold_reset;
		(chip_reset_req && !reset_indication_output_n)[*4];
	endsequence

	sequence s_reset_end;
		st_r == wtu_pkg::WTU_ST_RESET && rst_cnt_r == '0;
	endsequence

	AST_START_RUNNING: assert property (!seen_r |-> st_r == wtu_pkg::WTU_ST_RUN && !init_done_r)
		else $error("watchdog not running right after reset");

	AST_RESTART_RUN: assert property (s_reset_end |=> st_r == wtu_pkg::WTU_ST_RUN && !init_done_r)
		else $error("watchdog did not resume after internal reset");

	AST_COMPAT_IGNORE: assert property ((st_r == wtu_pkg::WTU_ST_RUN && !enh_r && init_done_r
		&& !ovf) |=> st_r == wtu_pkg::WTU_ST_RUN)
		else $error("disable accepted after end of initialisation");

	AST_ENH_DISABLE: assert property ((st_r == wtu_pkg::WTU_ST_RUN && enh_r && !ovf
		&& instr.timer_disable_instruction && !instr.timer_enable_instruction)
		|=> st_r == wtu_pkg::WTU_ST_STOP)
		else $error("enhanced disable did not stop the counter");

	AST_ENH_ENABLE: assert property ((st_r == wtu_pkg::WTU_ST_STOP && enh_r
		&& instr.timer_enable_instruction) |=> st_r == wtu_pkg::WTU_ST_RUN)
		else $error("enhanced enable did not restart the counter");

	AST_OVF_RESET: assert property (ovf |=> s_hold_reset)
		else $error("overflow did not raise the reset outputs");

	AST_COUNT_STEP: assert property ((st_r == wtu_pkg::WTU_ST_RUN && tick && !instr.service
		&& cnt_r != `WTU_CNT_MAX) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not advance on the prescaler tick");

	AST_STOP_HOLD: assert property ((st_r == wtu_pkg::WTU_ST_STOP && !instr.service)
		|=> $stable(cnt_r))
		else $error("counter moved while disabled");

	AST_SERVICE_LOAD: assert property (srv_eff |=> cnt_r == {$past(reload_r), `WTU_LOW_CLR})
		else $error("service did not load reload byte and clear low byte");

	AST_DEFAULTS: assert property (!seen_r |-> pre_r == wtu_pkg::WTU_DIV2
		&& reload_r == `WTU_REL_RST && cnt_r == '0)
		else $error("reset defaults wrong");

	AST_OVF_RELOAD: assert property (st_r == wtu_pkg::WTU_ST_RESET
		|-> cnt_r == {reload_r, `WTU_LOW_CLR})
		else $error("counter not held at reload during internal reset");

	AST_IRQ_LEVEL: assert property (ovf && irq_mask_r[`WTU_IRQ_OVF] |=> irq)
		else $error("masked-in overflow did not raise the interrupt");

endmodule

// file: wtu_defines.svh
// Purpose: named offsets, fields, reset values and timing figures of the watchdog
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef WTU_DEFINES_SVH
`define WTU_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ---------------------------------------------------------------
`define WTU_ADDR_W        12
`define WTU_OFF_CTRL      12'h000
`define WTU_OFF_COUNT     12'h004
`define WTU_OFF_STATE     12'h008
`define WTU_OFF_IRQ_STAT  12'h00C
`define WTU_OFF_IRQ_MASK  12'h010

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define WTU_CTRL_PRE_LSB  0
`define WTU_CTRL_PRE_MSB  1
`define WTU_CTRL_ENH_BIT  2
`define WTU_CTRL_REL_LSB  8
`define WTU_CTRL_REL_MSB  15
`define WTU_ST_RUN_BIT    0
`define WTU_ST_INIT_BIT   1
`define WTU_ST_RST_BIT    2
`define WTU_ST_STOP_BIT   3
`define WTU_IRQ_OVF       0
`define WTU_IRQ_DISIGN    1
`define WTU_IRQ_SRV       2
`define WTU_IRQ_W         3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WTU_PRE_RST       2'h0
`define WTU_REL_RST       8'h00
`define WTU_ENH_RST       1'b0
`define WTU_MASK_RST      3'h0

// ---------------------------------------------------------------
// counter and prescaler constants
// ---------------------------------------------------------------
`define WTU_CNT_W         16
`define WTU_CNT_MAX       16'hFFFF
`define WTU_LOW_CLR       8'h00
`define WTU_DIV2_MASK     8'h01
`define WTU_DIV4_MASK     8'h03
`define WTU_DIV128_MASK   8'h7F
`define WTU_DIV256_MASK   8'hFF

// ---------------------------------------------------------------
// default interval, quoted at a 40 MHz system clock
// ---------------------------------------------------------------
`define WTU_SPEC_MHZ        40
`define WTU_DEF_INTERVAL_NS 3280000
`define WTU_DEF_CYCLES      ((`WTU_DEF_INTERVAL_NS * `WTU_SPEC_MHZ) / 1000)
`define WTU_STRUCT_CYCLES   (2 * 65536)
`define WTU_RST_CYCLES_DEF  16

`endif

// file: wtu_pkg.sv
// Purpose: types shared by the watchdog files
// Assumes: nothing
// Notes:   instruction strobes travel together as one struct
package wtu_pkg;

	typedef struct packed {
		logic service;
		logic end_of_init_instruction;
		logic timer_disable_instruction;
		logic timer_enable_instruction;
	} wtu_instr_s;

	typedef enum logic [2:0] {
		WTU_ST_RUN   = 3'h1,
		WTU_ST_STOP  = 3'h2,
		WTU_ST_RESET = 3'h4
	} wtu_state_e;

	typedef enum logic [1:0] {
		WTU_DIV2   = 2'h0,
		WTU_DIV4   = 2'h1,
		WTU_DIV128 = 2'h2,
		WTU_DIV256 = 2'h3
	} wtu_div_e;

	typedef logic [7:0] wtu_reload_t;

endpackage

// file: wtu_prescaler.sv
// Purpose: divides the system clock into a one-cycle count enable
// Assumes: sel stable while counting; clear restarts the division
// Notes:   tick every 2, 4, 128 or 256 enabled cycles
`include "wtu_defines.svh"

module wtu_prescaler #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              enable,
	input  wire logic              clear,
	input  wire wtu_pkg::wtu_div_e sel,
	output logic                   tick
);

	logic [WIDTH-1:0] div_r;
	logic [7:0]       mask;

	if (WIDTH < 8) begin : g_chk
		$error("wtu_prescaler: WIDTH must be at least 8");
	end

	always_comb begin
		unique case (sel)
			wtu_pkg::WTU_DIV2:   mask = `WTU_DIV2_MASK;
			wtu_pkg::WTU_DIV4:   mask = `WTU_DIV4_MASK;
			wtu_pkg::WTU_DIV128: mask = `WTU_DIV128_MASK;
			wtu_pkg::WTU_DIV256: mask = `WTU_DIV256_MASK;
		endcase
	end

	// terminal value of the selected low bits marks the end of a period
	assign tick = enable && ((div_r[7:0] & mask) == mask);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else if (clear) begin
			div_r <= '0;
		end else if (enable) begin
			div_r <= div_r + 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fast_tick;
		tick && sel == wtu_pkg::WTU_DIV2 && !clear ##1 enable && !clear && $stable(sel);
	endsequence

	// a disable or a divider change in the middle cycle legally ends the pattern
	AST_DIV2_PERIOD: assert property (s_fast_tick ##1 (enable && $stable(sel)) |-> tick)
		else $error("divide-by-two tick missing two cycles after the last");

	AST_DIV4_GAP: assert property ((tick && sel == wtu_pkg::WTU_DIV4 && !clear) |=> !tick[*3])
		else $error("divide-by-four tick came too early");

endmodule

// file: wtu_core_model.sv
// Purpose: core model issuing watchdog instruction pulses
// Assumes: go is a one-cycle strobe from the bench, req held with it
// Notes:   keep_alive restarts the timer every PERIOD cycles
module wtu_core_model #(
	parameter int unsigned PERIOD = 300
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                go,
	input  wire wtu_pkg::wtu_instr_s req,
	input  wire logic                keep_alive,
	output wtu_pkg::wtu_instr_s      instr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] cnt_r;

	// ---------------------------------------------------------------
	// instruction pulses, one cycle each
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
			instr <= '0;
		end else begin
			cnt_r <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0000 : cnt_r + 16'h0001;
			// period kept well inside the shortest interval under test
			instr <= wtu_pkg::wtu_instr_s'((go ? 4'(req) : 4'h0)
				| {keep_alive && cnt_r == 16'h0000, 3'h0});
		end
	end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the watchdog timer unit
// Assumes: zero-wait APB slave, core model one cycle behind go
// Notes:   RST_CYCLES shortened to 4 to keep the run brief
`include "wtu_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RSTC = 4;
	localparam logic [3:0] SRV = 4'h8;
	localparam logic [3:0] EOI = 4'h4;
	localparam logic [3:0] DIS = 4'h2;
	localparam logic [3:0] ENA = 4'h1;
	typedef struct {
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] m;
		logic        err;
	} wtu_exp_s;

	logic                ref_clk = 1'b0;
	logic                rst_n;
	logic                go;
	logic                keep_alive;
	wtu_pkg::wtu_instr_s req;
	wtu_pkg::wtu_instr_s instr;
	logic [11:0]         paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         pwdata;
	logic [3:0]          pstrb;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                chip_reset_req;
	logic                reset_indication_output_n;
	logic                irq;
	int                  n_fail = 0;
	int                  tests_run = 0;
	wtu_exp_s            exp_q[$];

	always #25 ref_clk = ~ref_clk;

	wtu_watchdog #(.RST_CYCLES(RSTC)) u_wtu_watchdog (
		.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_reset_req(chip_reset_req),
		.reset_indication_output_n(reset_indication_output_n), .irq(irq)
	);

	wtu_core_model u_wtu_core_model (
		.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .req(req),
		.keep_alive(keep_alive), .instr(instr)
	);

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
			input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] m,
			input logic err);
		exp_q.push_back('{lo, hi, m, err});
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi,
			input logic [31:0] m);
		apb(a, 1'b0, 32'h0000_0000, lo, hi, m, 1'b0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 32'h0, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic issue(input logic [3:0] b);
		@(posedge ref_clk);
		req <= wtu_pkg::wtu_instr_s'(b);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
	endtask

	task automatic wait_ovf(output int c);
		c = 0;
		while (chip_reset_req !== 1'b1 && c < 2000) begin
			@(posedge ref_clk);
			c++;
		end
	endtask

	// ---------------------------------------------------------------
	// monitor: each finished transfer takes the oldest note
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		wtu_exp_s    e;
		logic [31:0] g;
		if (psel && penable && pready) begin
			e = exp_q.pop_front();
			g = prdata & e.m;
			tests_run++;
			if (pslverr !== e.err || ^g === 1'bx || g < e.lo || g > e.hi) begin
				n_fail++;
				$display("[FAIL] apb %h expected %h..%h err %b seen %h err %b",
					paddr, e.lo, e.hi, e.err, g, pslverr);
			end
		end
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		n_fail++;
		final_report();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		int          c;
		int          n;
		logic [7:0]  r;
		rst_n = 1'b0;
		go = 1'b0;
		keep_alive = 1'b0;
		req = '0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		void'($urandom(2));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(`WTU_OFF_CTRL, 32'h0, 32'h0, 32'hFF07);
		rd(`WTU_OFF_STATE, 32'h1, 32'h1, 32'hF);
		rd(`WTU_OFF_IRQ_MASK, 32'h0, 32'h0, 32'h7);
		apb(12'h014 + 12'(4 * ($urandom % 1000)), 1'b0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
		apb(`WTU_OFF_COUNT, 1'b1, 32'h1234, 32'h0, 32'h0, 32'h0, 1'b1);
		// compatible mode, before and after end of initialisation
		issue(DIS);
		rd(`WTU_OFF_STATE, 32'h8, 32'h8, 32'h9);
		issue(SRV);
		rd(`WTU_OFF_COUNT, 32'h0, 32'h0, 32'hFFFF);
		repeat (20) @(posedge ref_clk);
		rd(`WTU_OFF_COUNT, 32'h0, 32'h0, 32'hFFFF);
		issue(ENA);
		rd(`WTU_OFF_STATE, 32'h8, 32'h8, 32'h9);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(`WTU_OFF_STATE, 32'h1, 32'h1, 32'hF);
		issue(EOI);
		issue(DIS);
		rd(`WTU_OFF_STATE, 32'h3, 32'h3, 32'hF);
		rd(`WTU_OFF_IRQ_STAT, 32'h2, 32'h2, 32'h2);
		// enhanced mode, after end of initialisation
		wr(`WTU_OFF_CTRL, 32'h4);
		issue(DIS);
		rd(`WTU_OFF_STATE, 32'h8, 32'h8, 32'h9);
		issue(ENA);
		rd(`WTU_OFF_STATE, 32'h1, 32'h1, 32'h9);
		issue(DIS | ENA);
		rd(`WTU_OFF_STATE, 32'h1, 32'h1, 32'h9);
		// eight ticks expected per divider setting
		for (int d = 0; d < 4; d++) begin
			n = (d == 0) ? 2 : (d == 1) ? 4 : (d == 2) ? 128 : 256;
			wr(`WTU_OFF_CTRL, 32'(d));
			issue(SRV);
			repeat (8 * n) @(posedge ref_clk);
			rd(`WTU_OFF_COUNT, 32'd7, 32'd9, 32'hFFFF);
		end
		repeat (3) begin
			r = 8'($urandom);
			wr(`WTU_OFF_CTRL, {16'h0, r, 8'h00});
			issue(SRV);
			rd(`WTU_OFF_COUNT, {16'h0, r, 8'h00}, {16'h0, r, 8'h00}, 32'hFF00);
		end
		// lane 1 off: prescaler byte lands, reload byte stays
		pstrb <= 4'h1;
		wr(`WTU_OFF_CTRL, 32'h0000_AB00);
		pstrb <= 4'hF;
		rd(`WTU_OFF_CTRL, {16'h0, r, 8'h00}, {16'h0, r, 8'h00}, 32'hFF07);
		// shortest interval, overflow with interrupt unmasked
		wr(`WTU_OFF_IRQ_MASK, 32'h1);
		wr(`WTU_OFF_CTRL, 32'hFF00);
		issue(SRV);
		wait_ovf(c);
		chk("interval", 32'h1, 32'(c inside {[508:518]}));
		chk("indication", 32'h0, 32'(reset_indication_output_n));
		chk("irq raised", 32'h1, 32'(irq));
		c = 0;
		while (chip_reset_req === 1'b1 && c < 100) begin
			@(posedge ref_clk);
			c++;
		end
		chk("reset hold", 32'h1, 32'(c inside {[RSTC - 1:RSTC + 1]}));
		rd(`WTU_OFF_STATE, 32'h1, 32'h1, 32'hF);
		rd(`WTU_OFF_COUNT, 32'hFF00, 32'hFF00, 32'hFF00);
		rd(`WTU_OFF_IRQ_STAT, 32'h1, 32'h1, 32'h1);
		@(posedge ref_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(`WTU_OFF_IRQ_STAT, 32'h0, 32'h0, 32'h1);
		// regular service holds off overflow
		keep_alive <= 1'b1;
		c = 0;
		repeat (1500) begin
			@(posedge ref_clk);
			if (chip_reset_req !== 1'b0) c++;
		end
		chk("serviced", 32'h0, 32'(c));
		keep_alive <= 1'b0;
		wr(`WTU_OFF_IRQ_MASK, 32'h0);
		wait_ovf(c);
		chk("overflow", 32'h1, 32'(chip_reset_req));
		chk("irq masked", 32'h0, 32'(irq));
		final_report();
	end
endmodule
